// file: rtl/ncopr_regs.sv
// APB register slice: oscillator phase offsets and live readbacks
`timescale 1ns/1ns
`default_nettype none
`include "ncopr_defs.svh"

// How it works
// R01: phase offset writable while running, reset to zero
// R02: offset left justified, added to accumulator
// R03: one step is a 2^-16 turn
// R04: new offset waits for selected sync event
// R05: offset changes apply at once with datapath idle
// R06: fast reconfiguration overrides stored phase offsets
// R07: four amplitude readbacks, signed 16-bit
// R08: amplitude readback valid only in synthesis
// R09: amplitude sampled at each read, unlatched
// R10: 64-bit frequency readback for oscillators 0, 1
// R11: frequency sampled at each read, unlatched
// R12: frequency readback shows applied value only
module ncopr_regs #(
	parameter int NUM_SYNC = `NCOPR_NUM_SYNC,
	parameter int ADDR_W   = `NCOPR_ADDR_W
) (
	// Clock and reset
	input  wire logic                      pclk,
	input  wire logic                      presetn,
	// APB slave
	input  wire logic                      psel,
	input  wire logic                      penable,
	input  wire logic                      pwrite,
	input  wire logic [ADDR_W-1:0]         paddr,
	input  wire logic [31:0]               pwdata,
	output var  logic [31:0]               prdata,
	output var  logic                      pready,
	output var  logic                      pslverr,
	// Sync event sources
	input  wire logic [NUM_SYNC-1:0]       osc_update_sync,
	// Datapath inputs
	input  wire logic [1:0][31:0]          osc_accumulator,
	input  wire logic [1:0][31:0]          fr_phase,
	input  wire logic [3:0][15:0]          synth_amplitude,
	input  wire logic [1:0][63:0]          osc_frequency_setting,
	// Datapath outputs
	output var  ncopr_pkg::ncopr_ctrl_t    ctrl,
	output var  logic [1:0][31:0]          osc_phase,
	output var  logic [1:0][63:0]          osc_active_frequency
);
	import ncopr_pkg::*;

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	ncopr_ctrl_t      next_ctrl;
	ncopr_phase_t     slot [2];
	logic [1:0]       phase_wr;
	logic             apply;
	logic             sync_hit;
	logic             wr_access;
	logic             setup_phase;
	logic             hit;
	logic [31:0]      rd_word;
	logic [31:0]      next_prdata;
	logic             next_err;
	logic [1:0][63:0] next_freq;
	logic [1:0]       freq_pending;
	logic [3:0][15:0] amp_view;

	// ----------------------------------------------------------------
	// Sync selection
	// ----------------------------------------------------------------
	// While the datapath runs, only the selected source commits pending words
	assign sync_hit = osc_update_sync[ctrl.trig_sel];
	// With the datapath idle nothing runs, so updates commit at once (frequencies only with fast_reconfig_enable clear);
	// running updates are left to the sync event [R04]
	assign apply = sync_hit | ~ctrl.datapath_enable;

	// ----------------------------------------------------------------
	// APB phases
	// ----------------------------------------------------------------
	// Zero wait states; data is captured in setup, shown in access
	assign setup_phase = psel & ~penable;
	assign wr_access   = psel & penable & pwrite;
	assign pready      = psel & penable;

	// Phase word write strobes, one per slot
	always_comb begin
		phase_wr[0] = wr_access &&
			(paddr == `NCOPR_ADDR(`NCOPR_IDX_NCO2_PHASE_OFFSET));
		phase_wr[1] = wr_access &&
			(paddr == `NCOPR_ADDR(`NCOPR_IDX_NCO3_PHASE_OFFSET));
	end

	// ----------------------------------------------------------------
	// Phase offset slots for oscillators two and three
	// ----------------------------------------------------------------
	for (genvar g = 0; g < 2; g++) begin : g_slot
		ncopr_phase_slot #(
			.PH_W  (`NCOPR_PHASE_W),
			.ACC_W (`NCOPR_ACC_W)
		) u_slot (
			.pclk     (pclk),
			.presetn  (presetn),
			.wr_stb   (phase_wr[g]), // [R01]
			.wr_data  (pwdata[15:0]),
			.apply    (apply), // [R04]
			.fast_reconfig_enable    (ctrl.fast_reconfig_enable), // [R06]
			.acc      (osc_accumulator[g]),
			.fr_phase (fr_phase[g]),
			.offset   (slot[g].offset),
			.pending  (slot[g].pending),
			.phase    (slot[g].phase)
		);
		assign osc_phase[g] = slot[g].phase;
	end

	// ----------------------------------------------------------------
	// Active frequency words for oscillators zero and one
	// ----------------------------------------------------------------
	// Only a commit moves the setting into use, so readback never
	// shows a word that was written but not yet applied
	always_comb begin
		for (int i = 0; i < 2; i++) begin
			freq_pending[i] =
				osc_frequency_setting[i] != osc_active_frequency[i];
			next_freq[i] = osc_active_frequency[i];
			if (apply && !ctrl.fast_reconfig_enable) begin
				next_freq[i] = osc_frequency_setting[i]; // [R12]
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			osc_active_frequency <= {2{`NCOPR_FREQ_RESET}};
		end else begin
			osc_active_frequency <= next_freq;
		end
	end

	// ----------------------------------------------------------------
	// Control register
	// ----------------------------------------------------------------
	always_comb begin
		next_ctrl = ctrl;
		if (wr_access && paddr == `NCOPR_ADDR(`NCOPR_IDX_CTRL)) begin
			next_ctrl.datapath_enable    = pwdata[`NCOPR_CTRL_DP_BIT];
			next_ctrl.fast_reconfig_enable    = pwdata[`NCOPR_CTRL_FR_BIT];
			next_ctrl.synth_en = pwdata[`NCOPR_CTRL_SYN_BIT];
			next_ctrl.trig_sel =
				pwdata[`NCOPR_CTRL_SEL_MSB:`NCOPR_CTRL_SEL_LSB];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl <= `NCOPR_CTRL_RESET;
		end else begin
			ctrl <= next_ctrl;
		end
	end

	// ----------------------------------------------------------------
	// Amplitude view
	// ----------------------------------------------------------------
	// Outside synthesis the value is meaningless; zero is returned so
	// software sees something stable rather than stale data [R08]
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			amp_view[i] = ctrl.synth_en ? synth_amplitude[i] : 16'h0000;
		end
	end

	// ----------------------------------------------------------------
	// Read decode
	// ----------------------------------------------------------------
	// Each read takes the live value of its word; nothing is latched
	// across words, so a 64-bit word read in two halves can tear
	always_comb begin
		rd_word = 32'h0000_0000;
		hit     = 1'b1;
		unique case (paddr)
			`NCOPR_ADDR(`NCOPR_IDX_NCO2_PHASE_OFFSET):
				rd_word = {16'h0000, slot[0].offset};
			`NCOPR_ADDR(`NCOPR_IDX_NCO3_PHASE_OFFSET):
				rd_word = {16'h0000, slot[1].offset};
			`NCOPR_ADDR(`NCOPR_IDX_AMP0):
				rd_word = {16'h0000, amp_view[0]}; // [R07] [R09]
			`NCOPR_ADDR(`NCOPR_IDX_AMP1):
				rd_word = {16'h0000, amp_view[1]}; // [R07] [R09]
			`NCOPR_ADDR(`NCOPR_IDX_AMP2):
				rd_word = {16'h0000, amp_view[2]}; // [R07] [R09]
			`NCOPR_ADDR(`NCOPR_IDX_AMP3):
				rd_word = {16'h0000, amp_view[3]}; // [R07] [R09]
			`NCOPR_ADDR(`NCOPR_IDX_FREQ0):
				rd_word = osc_active_frequency[0][31:0]; // [R10] [R11]
			`NCOPR_ADDR_HI(`NCOPR_IDX_FREQ0):
				rd_word = osc_active_frequency[0][63:32]; // [R10] [R11]
			`NCOPR_ADDR(`NCOPR_IDX_FREQ1):
				rd_word = osc_active_frequency[1][31:0]; // [R10] [R11]
			`NCOPR_ADDR_HI(`NCOPR_IDX_FREQ1):
				rd_word = osc_active_frequency[1][63:32]; // [R10] [R11]
			`NCOPR_ADDR(`NCOPR_IDX_CTRL):
				rd_word = {26'h0000000, ctrl.trig_sel, 1'b0,
					ctrl.synth_en, ctrl.fast_reconfig_enable, ctrl.datapath_enable};
			`NCOPR_ADDR(`NCOPR_IDX_STATUS):
				rd_word = {28'h0000000, freq_pending,
					slot[1].pending, slot[0].pending};
			default:
				hit = 1'b0;
		endcase
	end

	// ----------------------------------------------------------------
	// Read data and error, captured in the setup cycle
	// ----------------------------------------------------------------
	always_comb begin
		next_prdata = prdata;
		next_err    = pslverr;
		if (setup_phase) begin
			next_prdata = pwrite ? 32'h0000_0000 : rd_word;
			next_err    = ~hit;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata  <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else begin
			prdata  <= next_prdata;
			pslverr <= next_err;
		end
	end

endmodule
`default_nettype wire

// file: rtl/ncopr_defs.svh
// Offsets, field positions, reset values and counts of the oscillator register slice
`ifndef NCOPR_DEFS_SVH
`define NCOPR_DEFS_SVH

// ----------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define NCOPR_IDX_NCO2_PHASE_OFFSET    10'h344
`define NCOPR_IDX_NCO3_PHASE_OFFSET    10'h346
`define NCOPR_IDX_AMP0      10'h378
`define NCOPR_IDX_AMP1      10'h37a
`define NCOPR_IDX_AMP2      10'h37c
`define NCOPR_IDX_AMP3      10'h37e
`define NCOPR_IDX_FREQ0     10'h380
`define NCOPR_IDX_FREQ1     10'h388
`define NCOPR_IDX_CTRL      10'h3c0
`define NCOPR_IDX_STATUS    10'h3c1

// Byte address of an index, and of the upper word of a 64-bit register
`define NCOPR_ADDR(i)       ({(i), 2'b00})
`define NCOPR_ADDR_HI(i)    ({((i) + 10'h001), 2'b00})

// ----------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------
`define NCOPR_CTRL_DP_BIT   0
`define NCOPR_CTRL_FR_BIT   1
`define NCOPR_CTRL_SYN_BIT  2
`define NCOPR_CTRL_SEL_LSB  4
`define NCOPR_CTRL_SEL_MSB  5

// ----------------------------------------------------------------
// Reset values and sizes
// ----------------------------------------------------------------
`define NCOPR_PHASE_RESET   16'h0000
`define NCOPR_CTRL_RESET    5'h00
`define NCOPR_FREQ_RESET    64'h0000_0000_0000_0000
`define NCOPR_PHASE_W       16
`define NCOPR_ACC_W         32
`define NCOPR_FREQ_W        64
`define NCOPR_AMP_W         16
`define NCOPR_NUM_SYNC      4
`define NCOPR_ADDR_W        12

`endif

// file: rtl/ncopr_pkg.sv
// Types shared by the oscillator register slice
package ncopr_pkg;

	// Live control bits driven to the datapath
	typedef struct packed {
		logic [1:0] trig_sel;
		logic       synth_en;
		logic       fast_reconfig_enable;
		logic       datapath_enable;
	} ncopr_ctrl_t;

	// What one phase slot shows: stored value, pending flag, phase out
	typedef struct packed {
		logic [15:0] offset;
		logic        pending;
		logic [31:0] phase;
	} ncopr_phase_t;

endpackage

// file: rtl/ncopr_phase_slot.sv
// One oscillator phase-offset slot: pending word, apply on sync, late add
`timescale 1ns/1ns
`default_nettype none
`include "ncopr_defs.svh"

module ncopr_phase_slot #(
	parameter int PH_W  = `NCOPR_PHASE_W,
	parameter int ACC_W = `NCOPR_ACC_W
) (
	// Clock and reset
	input  wire logic             pclk,
	input  wire logic             presetn,
	// Register side
	input  wire logic             wr_stb,
	input  wire logic [PH_W-1:0]  wr_data,
	input  wire logic             apply,
	input  wire logic             fast_reconfig_enable,
	// Datapath side
	input  wire logic [ACC_W-1:0] acc,
	input  wire logic [ACC_W-1:0] fr_phase,
	output var  logic [PH_W-1:0]  offset,
	output var  logic             pending,
	output var  logic [ACC_W-1:0] phase
);

	logic [PH_W-1:0]  active;
	logic [PH_W-1:0]  next_offset;
	logic [PH_W-1:0]  next_active;
	logic             next_pending;
	logic [ACC_W-1:0] next_phase;

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		next_offset  = wr_stb ? wr_data : offset;
		next_active  = active;
		next_pending = pending;
		// Stored word waits for the chosen sync event [R04]
		if (apply && pending) begin
			next_active  = offset;
			next_pending = 1'b0;
		end
		// A write in the apply cycle stays pending: set beats clear [R04]
		if (wr_stb) begin
			next_pending = 1'b1;
		end
		// Left justified, zero filled, added after the accumulator [R02]
		// Modulo add, so signed and unsigned readings agree [R03]
		next_phase = acc + {active, {(ACC_W-PH_W){1'b0}}}; // [R01]
		// Fast reconfiguration supplies phase, stored word unused [R06]
		if (fast_reconfig_enable) begin
			next_phase = fr_phase;
		end
	end

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			offset  <= `NCOPR_PHASE_RESET;
			active  <= `NCOPR_PHASE_RESET;
			pending <= 1'b0;
			phase   <= '0;
		end else begin
			offset  <= next_offset;
			active  <= next_active;
			pending <= next_pending;
			phase   <= next_phase;
		end
	end

endmodule
`default_nettype wire

// file: tb/ncopr_regs_props.sv
// Concurrent checks on the ports of the oscillator register slice
`timescale 1ns/1ns
`default_nettype none
`include "ncopr_defs.svh"
module ncopr_regs_chk #(
	parameter int NUM_SYNC = 4,
	parameter int ADDR_W   = 12
) (
	// Clock and reset
	input wire logic                   pclk,
	input wire logic                   presetn,
	// APB slave
	input wire logic                   psel,
	input wire logic                   penable,
	input wire logic                   pwrite,
	input wire logic [ADDR_W-1:0]      paddr,
	input wire logic [31:0]            pwdata,
	input wire logic [31:0]            prdata,
	input wire logic                   pready,
	input wire logic                   pslverr,
	// Datapath
	input wire logic [NUM_SYNC-1:0]    osc_update_sync,
	input wire logic [1:0][31:0]       osc_accumulator,
	input wire logic [1:0][31:0]       fr_phase,
	input wire logic [3:0][15:0]       synth_amplitude,
	input wire logic [1:0][63:0]       osc_frequency_setting,
	input wire ncopr_pkg::ncopr_ctrl_t ctrl,
	input wire logic [1:0][31:0]       osc_phase,
	input wire logic [1:0][63:0]       osc_active_frequency
);
	// ----------------------------------------------------------------
	// Datapath relations
	// ----------------------------------------------------------------
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// Offset sits above bit 15, so the low half is the accumulator alone
	chk_phase_low: assert property (!ctrl.fast_reconfig_enable |=> osc_phase[0][15:0] ==
		$past(osc_accumulator[0][15:0])) else $error("phase low half bad");
	chk_phase_fast: assert property (ctrl.fast_reconfig_enable |=>
		osc_phase == $past(fr_phase)) else $error("fast phase bad");
	chk_freq_frozen: assert property (ctrl.fast_reconfig_enable |=>
		$stable(osc_active_frequency)) else $error("freq moved");
	chk_freq_idle: assert property (!ctrl.datapath_enable && !ctrl.fast_reconfig_enable |=>
		osc_active_frequency == $past(osc_frequency_setting))
		else $error("idle freq bad");
	chk_freq_wait: assert property (ctrl.datapath_enable && !ctrl.fast_reconfig_enable &&
		osc_update_sync == '0 |=> $stable(osc_active_frequency))
		else $error("freq applied early");
	// ----------------------------------------------------------------
	// Readbacks, captured at the setup edge
	// ----------------------------------------------------------------
	chk_amp_live: assert property (psel && !penable && !pwrite &&
		paddr == `NCOPR_ADDR(`NCOPR_IDX_AMP0) && ctrl.synth_en |=>
		prdata[15:0] == $past(synth_amplitude[0])) else $error("amp bad");
	chk_amp_off: assert property (psel && !penable && !pwrite &&
		paddr == `NCOPR_ADDR(`NCOPR_IDX_AMP1) && !ctrl.synth_en |=>
		prdata == 32'h0) else $error("amp not zero");
	chk_freq_read: assert property (psel && !penable && !pwrite &&
		paddr == `NCOPR_ADDR(`NCOPR_IDX_FREQ0) |=>
		prdata == $past(osc_active_frequency[0][31:0]))
		else $error("freq read bad");
endmodule
`default_nettype wire

// file: tb/tb_ncopr_regs.sv
// Self-checking bench of the oscillator register slice
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, ex, got) begin samples_checked++; \
	if ((got) !== (ex)) begin n_fail++; \
	$display("wrong value %s exp %h got %h", nm, (ex), (got)); end end
module tb_ncopr_regs;
	import ncopr_pkg::*;
	typedef struct packed {
		logic w; logic [11:0] a; logic [31:0] d; logic [31:0] e; logic r;
	} ncopr_row_t;
	logic              pclk = 1'b0, presetn = 1'b0;
	logic              psel = 1'b0, penable = 1'b0, pwrite = 1'b0, er;
	logic [11:0]       paddr = 12'h000;
	logic [31:0]       pwdata = 32'h0, prdata, rd;
	logic              pready, pslverr;
	logic [3:0]        osc_update_sync = 4'h0;
	logic [1:0][31:0]  osc_accumulator = {32'h20000002, 32'h10000001};
	logic [1:0][31:0]  fr_phase = {32'h5555aaaa, 32'haaaa5555};
	logic [3:0][15:0]  synth_amplitude = 64'h8001_7ffe_1234_fedc;
	logic [1:0][63:0]  osc_frequency_setting =
		{64'hfedcba9876543210, 64'h0123456789abcdef};
	ncopr_ctrl_t       ctrl;
	logic [1:0][31:0]  osc_phase;
	logic [1:0][63:0]  osc_active_frequency;
	int                n_fail = 0, samples_checked = 0;
	ncopr_row_t        rows [14] = '{
		'{1'b0, 12'hd18, 32'h0, 32'h0, 1'b0}, '{1'b1, 12'hf00, 32'h4, 32'h0, 1'b0},
		'{1'b0, 12'hf00, 32'h0, 32'h4, 1'b0},
		'{1'b1, 12'hd10, 32'hffff8001, 32'h0, 1'b0},
		'{1'b0, 12'hd10, 32'h0, 32'h8001, 1'b0},
		'{1'b0, 12'hde0, 32'h0, 32'hfedc, 1'b0},
		'{1'b0, 12'hdf8, 32'h0, 32'h8001, 1'b0},
		'{1'b0, 12'he00, 32'h0, 32'h89abcdef, 1'b0},
		'{1'b0, 12'he04, 32'h0, 32'h01234567, 1'b0},
		'{1'b1, 12'he20, 32'h1, 32'h0, 1'b0},
		'{1'b0, 12'he20, 32'h0, 32'h76543210, 1'b0},
		'{1'b0, 12'he24, 32'h0, 32'hfedcba98, 1'b0},
		'{1'b1, 12'h004, 32'h1, 32'h0, 1'b1}, '{1'b0, 12'h004, 32'h0, 32'h0, 1'b1}};
	// Design under test
	ncopr_regs dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.osc_update_sync(osc_update_sync), .osc_accumulator(osc_accumulator),
		.fr_phase(fr_phase), .synth_amplitude(synth_amplitude),
		.osc_frequency_setting(osc_frequency_setting), .ctrl(ctrl),
		.osc_phase(osc_phase), .osc_active_frequency(osc_active_frequency));
	// 25 MHz clock
	always #20 pclk = ~pclk;
	// ----------------------------------------------------------------
	// Bus and sync tasks
	// ----------------------------------------------------------------
	// Request held until pready is seen; only the watchdog ends a hang
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic pulse(input logic [3:0] v);
		@(posedge pclk);
		osc_update_sync <= v;
		@(posedge pclk);
		osc_update_sync <= 4'h0;
		repeat (3) @(posedge pclk);
	endtask
	task automatic complete_run;
		$display("checked %0d failed %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		repeat (3) @(posedge pclk);
		@(negedge pclk);
		`CHK("ctrl", 5'h00, ctrl)
		`CHK("freq", 128'h0, osc_active_frequency)
		@(posedge pclk);
		presetn <= 1'b1;
		// Offsets are written with the datapath idle
		for (int i = 0; i < 14; i++) begin
			apb(rows[i].w, rows[i].a, rows[i].d);
			if (!rows[i].w) `CHK("prdata", rows[i].e, rd)
			`CHK("pslverr", rows[i].r, er)
		end
		`CHK("osc2 phase", 32'h90010001, osc_phase[0])
		apb(1'b1, 12'hd18, 32'hffff);
		repeat (3) @(posedge pclk);
		`CHK("osc3 phase", 32'h1fff0002, osc_phase[1])
		// Running: new values wait for the selected sync source
		apb(1'b1, 12'hf00, 32'h25);
		osc_frequency_setting[0] <= 64'h1;
		apb(1'b1, 12'hd10, 32'h1);
		apb(1'b0, 12'hf04, 32'h0);
		`CHK("pending", 1'b1, rd[0])
		pulse(4'h2);
		`CHK("held phase", 32'h90010001, osc_phase[0])
		apb(1'b0, 12'he00, 32'h0);
		`CHK("freq rb", 32'h89abcdef, rd)
		pulse(4'h4);
		`CHK("new phase", 32'h10010001, osc_phase[0])
		`CHK("new freq", 64'h1, osc_active_frequency[0])
		synth_amplitude[1] <= 16'h4321;
		apb(1'b0, 12'hde8, 32'h0);
		`CHK("amp1", 32'h4321, rd)
		// Fast reconfiguration overrides the stored offset
		apb(1'b1, 12'hf00, 32'h27);
		apb(1'b1, 12'hd10, 32'h7);
		pulse(4'h4);
		`CHK("fr phase", 32'haaaa5555, osc_phase[0])
		apb(1'b1, 12'hf00, 32'h0);
		apb(1'b0, 12'hde8, 32'h0);
		`CHK("amp off", 32'h0, rd)
		// Reset in mid-run clears the offsets
		presetn <= 1'b0;
		@(negedge pclk);
		`CHK("ctrl rst", 5'h00, ctrl)
		`CHK("phase rst", 64'h0, osc_phase)
		@(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, 12'hd10, 32'h0);
		`CHK("nco2_phase_offset rst", 32'h0, rd)
		complete_run();
	end
	// Watchdog at 2500 cycles, far beyond the hundred or so cycles the tests need
	initial begin
		#100000;
		n_fail++;
		complete_run();
	end
endmodule
bind ncopr_regs ncopr_regs_chk #(.NUM_SYNC(NUM_SYNC), .ADDR_W(ADDR_W)) chk_u (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .osc_update_sync(osc_update_sync),
	.osc_accumulator(osc_accumulator), .fr_phase(fr_phase),
	.synth_amplitude(synth_amplitude), .ctrl(ctrl), .osc_phase(osc_phase),
	.osc_frequency_setting(osc_frequency_setting),
	.osc_active_frequency(osc_active_frequency));
`default_nettype wire
